//--- core/cbs_pkg.sv
// Shared types, constants and bus helpers for the bus cycle sequencer
package cbs_pkg;

    // Reset values of the processor state
    localparam logic [15:0] RESET_PC = 16'h0000;
    localparam logic [7:0] RESET_ACC = 8'h00;
    localparam logic [15:0] RESET_PTR = 16'h0000;

    // Opcode field positions and group codes
    localparam int OP_ACC_BIT = 6;
    localparam int OP_GROUP_BIT = 7;
    localparam logic [1:0] MODE_FIELD_IMM = 2'h0;
    localparam logic [1:0] MODE_FIELD_DIR = 2'h1;
    localparam logic [1:0] MODE_FIELD_IDX = 2'h2;
    localparam logic [7:0] OP_JUMP_IDX = 8'h6e;

    // Low nibble codes of the operation groups
    localparam logic [3:0] LO_SUB = 4'h0;
    localparam logic [3:0] LO_CMP = 4'h1;
    localparam logic [3:0] LO_SBC = 4'h2;
    localparam logic [3:0] LO_AND = 4'h4;
    localparam logic [3:0] LO_BIT = 4'h5;
    localparam logic [3:0] LO_LOAD8 = 4'h6;
    localparam logic [3:0] LO_STORE8 = 4'h7;
    localparam logic [3:0] LO_EOR = 4'h8;
    localparam logic [3:0] LO_ADC = 4'h9;
    localparam logic [3:0] LO_ORA = 4'ha;
    localparam logic [3:0] LO_ADD = 4'hb;
    localparam logic [3:0] LO_CMPX = 4'hc;
    localparam logic [3:0] LO_LOAD16 = 4'he;
    localparam logic [3:0] LO_STORE16 = 4'hf;

    // Upper byte of a direct-mode operand address
    localparam logic [7:0] DIRECT_PAGE = 8'h00;

    // Bus cycle within an instruction, Gray coded along the path
    typedef enum logic [2:0] {
        CYC_1 = 3'h0,
        CYC_2 = 3'h1,
        CYC_3 = 3'h3,
        CYC_4 = 3'h2,
        CYC_5 = 3'h6,
        CYC_6 = 3'h7
    } cbs_cyc_e;

    typedef enum logic [1:0] {
        MODE_IMM = 2'h0,
        MODE_DIR = 2'h1,
        MODE_IDX = 2'h2
    } cbs_mode_e;

    typedef enum logic [2:0] {
        CL_NONE = 3'h0,
        CL_READ8 = 3'h1,
        CL_READ16 = 3'h2,
        CL_STORE8 = 3'h3,
        CL_STORE16 = 3'h4,
        CL_JUMP = 3'h5
    } cbs_class_e;

    typedef enum logic [1:0] {
        REG_A = 2'h0,
        REG_B = 2'h1,
        REG_X = 2'h2,
        REG_S = 2'h3
    } cbs_reg_e;

    // Decoded opcode
    typedef struct packed {
        logic valid;
        cbs_mode_e mode;
        cbs_class_e cls;
        logic load;
        cbs_reg_e sel;
    } cbs_dec_s;

    // Processor bus as driven by the sequencer
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] data;
        logic data_oe;
        logic memory_cycle_valid;
        logic rnw;
    } cbs_bus_s;

    // Programmer-visible registers
    typedef struct packed {
        logic [15:0] pc;
        logic [7:0] acc_a;
        logic [7:0] acc_b;
        logic [15:0] idx;
        logic [15:0] sp;
    } cbs_core_s;

    // Whole state of the sequencer
    typedef struct packed {
        cbs_cyc_e cyc;
        cbs_dec_s dec;
        cbs_core_s core;
        logic [15:0] ea;
        logic [7:0] hi;
        cbs_bus_s bus;
    } cbs_state_s;

    // Real read transfer
    function automatic cbs_bus_s bus_read(input logic [15:0] addr);
        cbs_bus_s b;
        b = '{addr: addr, data: 8'h00, data_oe: 1'b0, memory_cycle_valid: 1'b1, rnw: 1'b1};
        return b;
    endfunction

    // Internal cycle: address shown, nothing transferred
    function automatic cbs_bus_s bus_idle(input logic [15:0] addr);
        cbs_bus_s b;
        b = '{addr: addr, data: 8'h00, data_oe: 1'b0, memory_cycle_valid: 1'b0, rnw: 1'b1};
        return b;
    endfunction

    // Real write transfer
    function automatic cbs_bus_s bus_write(input logic [15:0] addr,
                                           input logic [7:0] data);
        cbs_bus_s b;
        b = '{addr: addr, data: data, data_oe: 1'b1, memory_cycle_valid: 1'b1, rnw: 1'b0};
        return b;
    endfunction

endpackage

//--- core/cbs_opdecode.sv
// Opcode decoder: addressing mode, transfer class and target register
`timescale 1ns/1ps
module cbs_opdecode (
    // Opcode byte
    input wire logic [7:0] i_opcode,
    // Decoded result
    output cbs_pkg::cbs_dec_s o_dec
);

    logic [3:0] lo;
    logic [1:0] mf;
    cbs_pkg::cbs_reg_e acc;
    cbs_pkg::cbs_reg_e ptr;

    assign lo = i_opcode[3:0];
    assign mf = i_opcode[5:4];
    assign acc = i_opcode[cbs_pkg::OP_ACC_BIT] ? cbs_pkg::REG_B
                                                : cbs_pkg::REG_A;
    assign ptr = i_opcode[cbs_pkg::OP_ACC_BIT] ? cbs_pkg::REG_X
                                                : cbs_pkg::REG_S;

    // Opcodes of one group share a class so their bus cycles match
    always_comb begin
        o_dec = '{valid: 1'b0, mode: cbs_pkg::MODE_IMM,
                  cls: cbs_pkg::CL_NONE, load: 1'b0, sel: cbs_pkg::REG_A};
        if (i_opcode == cbs_pkg::OP_JUMP_IDX) begin
            o_dec.valid = 1'b1;
            o_dec.mode = cbs_pkg::MODE_IDX;
            o_dec.cls = cbs_pkg::CL_JUMP;
        end else if (i_opcode[cbs_pkg::OP_GROUP_BIT] &&
                     mf != 2'h3) begin
            o_dec.mode = cbs_pkg::cbs_mode_e'(mf);
            o_dec.sel = acc;
            unique case (lo)
                cbs_pkg::LO_SUB, cbs_pkg::LO_CMP, cbs_pkg::LO_SBC,
                cbs_pkg::LO_AND, cbs_pkg::LO_BIT, cbs_pkg::LO_EOR,
                cbs_pkg::LO_ADC, cbs_pkg::LO_ORA, cbs_pkg::LO_ADD: begin
                    o_dec.valid = 1'b1;
                    o_dec.cls = cbs_pkg::CL_READ8;
                end
                cbs_pkg::LO_LOAD8: begin
                    o_dec.valid = 1'b1;
                    o_dec.cls = cbs_pkg::CL_READ8;
                    o_dec.load = 1'b1;
                end
                cbs_pkg::LO_STORE8: begin
                    // Only the direct store sequence is carried here
                    o_dec.valid = (mf == cbs_pkg::MODE_FIELD_DIR);
                    o_dec.cls = cbs_pkg::CL_STORE8;
                end
                cbs_pkg::LO_CMPX: begin
                    o_dec.valid = !i_opcode[cbs_pkg::OP_ACC_BIT];
                    o_dec.cls = cbs_pkg::CL_READ16;
                    o_dec.sel = cbs_pkg::REG_X;
                end
                cbs_pkg::LO_LOAD16: begin
                    o_dec.valid = 1'b1;
                    o_dec.cls = cbs_pkg::CL_READ16;
                    o_dec.load = 1'b1;
                    o_dec.sel = ptr;
                end
                cbs_pkg::LO_STORE16: begin
                    o_dec.valid = (mf == cbs_pkg::MODE_FIELD_DIR);
                    o_dec.cls = cbs_pkg::CL_STORE16;
                    o_dec.sel = ptr;
                end
                default: begin
                    o_dec.valid = 1'b0;
                end
            endcase
        end
    end

endmodule

//--- core/cbs_addr_calc.sv
// Indexed address arithmetic: partial and fully carried sums
`timescale 1ns/1ps
module cbs_addr_calc (
    // Index register and unsigned offset
    input wire logic [15:0] i_index,
    input wire logic [7:0] i_offset,
    // Sums
    output logic [15:0] o_sum_nocarry,
    output logic [15:0] o_sum_carry
);

    // Low byte alone first, as the bus shows it before the carry settles
    assign o_sum_nocarry = {i_index[15:8], 8'(i_index[7:0] + i_offset)};
    assign o_sum_carry = i_index + {8'h00, i_offset};

endmodule

//--- core/cbs_sequencer.sv
// Instruction bus cycle sequencer for the 8-bit processor core
// Cycle plan by class; cycle one is always the opcode fetch
//   unknown opcode: skipped, the next byte is fetched at once
//   immediate 8-bit: operand at the pc in cycle two
//   immediate 16-bit: high byte, then low byte, at the pc
//   direct reads: address byte, then operand in page zero
//   direct 16-bit: high byte, then low byte at the next address
//   direct accumulator store: idle, then write at that address
//   direct pointer store: idle, high byte, low byte one above
//   indexed: offset, idle at index, idle at the partial sum
//   indexed jump: fetch resumes at the carried sum
//   indexed 8-bit: operand at the carried sum in cycle five
//   indexed 16-bit: high byte at the carried sum, low byte above
//
// Timing
//   Each bus cycle is one clock; every bus field changes at the edge.
//   Read data is taken at the rising edge that ends its cycle.
//   Write data stands for the whole write cycle.
//   The opcode is decoded straight off the data bus in the fetch,
//   so memory access time plus decode sets the longest path.
//
// Limitations
//   Only the bus is sequenced: no arithmetic result and no flags.
//   Extended, implied, relative, stack and interrupt codes are absent
//   and cost one fetch cycle each, so software must avoid them.
//   Direct operands always live in page zero.
//   No wait states: memory must answer within the same bus cycle.
//   The data lines never float; data_oe tells a pad when to drive.
`timescale 1ns/1ps
module cbs_sequencer (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    // Data bus input half
    input wire logic [7:0] i_data,
    // Address, data output half, enable, valid and read lines
    output cbs_pkg::cbs_bus_s o_bus,
    // Programmer-visible registers for observation
    output cbs_pkg::cbs_core_s o_core
);

    // State after reset: first opcode fetch already on the bus
    localparam cbs_pkg::cbs_state_s RST_STATE = '{
        cyc: cbs_pkg::CYC_1,
        dec: '{valid: 1'b0, mode: cbs_pkg::MODE_IMM,
               cls: cbs_pkg::CL_NONE, load: 1'b0, sel: cbs_pkg::REG_A},
        core: '{pc: cbs_pkg::RESET_PC, acc_a: cbs_pkg::RESET_ACC,
                acc_b: cbs_pkg::RESET_ACC, idx: cbs_pkg::RESET_PTR,
                sp: cbs_pkg::RESET_PTR},
        ea: 16'h0000,
        hi: 8'h00,
        bus: '{addr: cbs_pkg::RESET_PC, data: 8'h00, data_oe: 1'b0,
               memory_cycle_valid: 1'b1, rnw: 1'b1}
    };

    // Present state and the value it takes at the next edge
    cbs_pkg::cbs_state_s r;
    cbs_pkg::cbs_state_s n;

    // Decode of the data bus and the two indexed sums
    cbs_pkg::cbs_dec_s fetched;
    logic [15:0] sum_nocarry;
    logic [15:0] sum_carry;

    // Value of a selected register, widened to 16 bits
    function automatic logic [15:0] reg_pick(input cbs_pkg::cbs_core_s c,
                                             input cbs_pkg::cbs_reg_e s);
        logic [15:0] v;

        unique case (s)
            cbs_pkg::REG_A: v = {8'h00, c.acc_a};
            cbs_pkg::REG_B: v = {8'h00, c.acc_b};
            cbs_pkg::REG_X: v = c.idx;
            cbs_pkg::REG_S: v = c.sp;
        endcase
        return v;
    endfunction

    // Loads into a selected register; accumulators keep the low byte
    function automatic cbs_pkg::cbs_core_s reg_load(
        input cbs_pkg::cbs_core_s c,
        input cbs_pkg::cbs_dec_s d,
        input logic [15:0] v);
        cbs_pkg::cbs_core_s o;

        o = c;
        if (d.load) begin
            unique case (d.sel)
                cbs_pkg::REG_A: o.acc_a = v[7:0];
                cbs_pkg::REG_B: o.acc_b = v[7:0];
                cbs_pkg::REG_X: o.idx = v;
                cbs_pkg::REG_S: o.sp = v;
            endcase
        end
        return o;
    endfunction

    // Decode straight off the data bus during the fetch cycle
    cbs_opdecode u_decode (
        .i_opcode(i_data),
        .o_dec(fetched)
    );

    // Offset sits in the low byte of the effective address until cycle 5
    cbs_addr_calc u_addr (
        .i_index(r.core.idx),
        .i_offset(r.ea[7:0]),
        .o_sum_nocarry(sum_nocarry),
        .o_sum_carry(sum_carry)
    );

    // Each pass decides the bus of the next cycle and captures this one's
    // data; the bus is then a pure flop output, so it never glitches.
    always_comb begin
        logic [15:0] pc_inc;
        logic [15:0] ea_inc;
        logic [15:0] word;

        // Running pointers and the byte pair of a 16-bit read
        pc_inc = 16'(r.core.pc + 16'h0001);
        ea_inc = 16'(r.ea + 16'h0001);
        word = {r.hi, i_data};
        n = r;

        unique case (r.cyc)
            cbs_pkg::CYC_1: begin
                // Opcode taken; unknown codes are passed over at once
                n.dec = fetched;
                n.core.pc = pc_inc;
                if (fetched.valid) begin
                    n.cyc = cbs_pkg::CYC_2;
                    n.bus = cbs_pkg::bus_read(pc_inc);
                end else begin
                    n.cyc = cbs_pkg::CYC_1;
                    n.bus = cbs_pkg::bus_read(pc_inc);
                end
            end

            // Second byte: operand, address byte or offset
            cbs_pkg::CYC_2: begin
                n.core.pc = pc_inc;
                n.hi = i_data;
                n.ea = {cbs_pkg::DIRECT_PAGE, i_data};
                unique case (r.dec.mode)
                    cbs_pkg::MODE_IMM: begin
                        if (r.dec.cls == cbs_pkg::CL_READ8) begin
                            n.core = reg_load(r.core, r.dec,
                                              {8'h00, i_data});
                            n.core.pc = pc_inc;
                            n.cyc = cbs_pkg::CYC_1;
                            n.bus = cbs_pkg::bus_read(pc_inc);
                        end else begin
                            n.cyc = cbs_pkg::CYC_3;
                            n.bus = cbs_pkg::bus_read(pc_inc);
                        end
                    end

                    cbs_pkg::MODE_DIR: begin
                        n.cyc = cbs_pkg::CYC_3;
                        if (r.dec.cls == cbs_pkg::CL_STORE8 ||
                            r.dec.cls == cbs_pkg::CL_STORE16) begin
                            // Address settles one cycle before the write
                            n.bus = cbs_pkg::bus_idle(n.ea);
                        end else begin
                            n.bus = cbs_pkg::bus_read(n.ea);
                        end
                    end

                    default: begin
                        // Indexed: the index itself goes out first
                        n.cyc = cbs_pkg::CYC_3;
                        n.bus = cbs_pkg::bus_idle(r.core.idx);
                    end
                endcase
            end

            // Third cycle: low byte, operand, idle before a store or index
            cbs_pkg::CYC_3: begin
                unique case (r.dec.mode)
                    cbs_pkg::MODE_IMM: begin
                        n.core = reg_load(r.core, r.dec, word);
                        n.core.pc = pc_inc;
                        n.cyc = cbs_pkg::CYC_1;
                        n.bus = cbs_pkg::bus_read(pc_inc);
                    end

                    cbs_pkg::MODE_DIR: begin
                        if (r.dec.cls == cbs_pkg::CL_READ8) begin
                            n.core = reg_load(r.core, r.dec,
                                              {8'h00, i_data});
                            n.cyc = cbs_pkg::CYC_1;
                            n.bus = cbs_pkg::bus_read(r.core.pc);
                        end else if (r.dec.cls == cbs_pkg::CL_READ16) begin
                            n.hi = i_data;
                            n.cyc = cbs_pkg::CYC_4;
                            n.bus = cbs_pkg::bus_read(ea_inc);
                        end else if (r.dec.cls == cbs_pkg::CL_STORE8) begin
                            n.cyc = cbs_pkg::CYC_4;
                            n.bus = cbs_pkg::bus_write(r.ea,
                                r.dec.sel == cbs_pkg::REG_B ?
                                r.core.acc_b : r.core.acc_a);
                        end else begin
                            n.cyc = cbs_pkg::CYC_4;
                            n.bus = cbs_pkg::bus_write(r.ea,
                                reg_pick(r.core, r.dec.sel)
                                [15:8]);
                        end
                    end

                    default: begin
                        // Partial sum shown while the carry is pending
                        n.cyc = cbs_pkg::CYC_4;
                        n.bus = cbs_pkg::bus_idle(sum_nocarry);
                    end
                endcase
            end

            // Fourth cycle: last direct read, first write or partial sum
            cbs_pkg::CYC_4: begin
                n.cyc = cbs_pkg::CYC_1;
                n.bus = cbs_pkg::bus_read(r.core.pc);
                // Pointer store and indexed read branches extend past this fetch; a jump moves it
                if (r.dec.mode == cbs_pkg::MODE_DIR) begin
                    if (r.dec.cls == cbs_pkg::CL_READ16) begin
                        n.core = reg_load(r.core, r.dec, word);
                    end else if (r.dec.cls == cbs_pkg::CL_STORE16) begin
                        n.cyc = cbs_pkg::CYC_5;
                        n.bus = cbs_pkg::bus_write(ea_inc,
                            reg_pick(r.core, r.dec.sel)[7:0]);
                    end
                end else if (r.dec.cls == cbs_pkg::CL_JUMP) begin
                    // Jump lands on the fully carried sum
                    n.core.pc = sum_carry;
                    n.bus = cbs_pkg::bus_read(sum_carry);
                end else begin
                    n.ea = sum_carry;
                    n.cyc = cbs_pkg::CYC_5;
                    n.bus = cbs_pkg::bus_read(sum_carry);
                end
            end

            // Fifth cycle: pointer low byte written or indexed operand
            cbs_pkg::CYC_5: begin
                n.cyc = cbs_pkg::CYC_1;
                n.bus = cbs_pkg::bus_read(r.core.pc);
                // Only an indexed 16-bit read goes on to a sixth cycle
                if (r.dec.mode == cbs_pkg::MODE_IDX) begin
                    if (r.dec.cls == cbs_pkg::CL_READ8) begin
                        n.core = reg_load(r.core, r.dec,
                                          {8'h00, i_data});
                    end else begin
                        n.hi = i_data;
                        n.cyc = cbs_pkg::CYC_6;
                        n.bus = cbs_pkg::bus_read(ea_inc);
                    end
                end
            end

            // Sixth cycle: low byte of an indexed 16-bit read
            cbs_pkg::CYC_6: begin
                n.core = reg_load(r.core, r.dec, word);
                n.cyc = cbs_pkg::CYC_1;
                n.bus = cbs_pkg::bus_read(r.core.pc);
            end

            default: begin
                // Unused cycle codes recover with a fetch at the pc
                n.cyc = cbs_pkg::CYC_1;
                n.bus = cbs_pkg::bus_read(r.core.pc);
            end
        endcase
    end

    // Single state register
    // Reset is asynchronous so the bus is defined before the clock runs
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            r <= RST_STATE;
        end else begin
            r <= n;
        end
    end

    // Outputs straight from the state flops
    // No logic after the flops, so the pads see clean edges
    assign o_bus = r.bus;
    assign o_core = r.core;

endmodule

//--- bench/cbs_memory.sv
// Memory model on the far side of the sequencer's system bus
`timescale 1ns/1ps
module cbs_memory (
    // Clock
    input wire logic i_core_clk,
    // Bus as driven by the sequencer
    input cbs_pkg::cbs_bus_s i_bus,
    // Read data back to the sequencer
    output logic [7:0] o_data
);
    logic [7:0] mem [0:65535];
    logic [7:0] last_r = 8'h00;

    // Cleared store; the bench loads its program after time zero
    initial begin
        for (int k = 0; k < 65536; k++) begin
            mem[k] = 8'h00;
        end
    end

    // Undriven bus shows the inverse of the last byte, never a stale copy
    assign o_data = (i_bus.memory_cycle_valid && i_bus.rnw) ? mem[i_bus.addr]
                                             : ~last_r;

    // Writes land only on valid cycles, so idle addresses stay untouched
    always @(posedge i_core_clk) begin
        if (i_bus.memory_cycle_valid && !i_bus.rnw) begin
            mem[i_bus.addr] <= i_bus.data;
        end
        if (i_bus.memory_cycle_valid && i_bus.rnw) begin
            last_r <= mem[i_bus.addr];
        end
    end
endmodule

//--- bench/cbs_sequencer_properties.sv
// Bus timing checker bound to the sequencer ports
`timescale 1ns/1ps
module cbs_sequencer_properties (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    // Watched ports
    input wire logic [7:0] i_data,
    input cbs_pkg::cbs_bus_s o_bus,
    input cbs_pkg::cbs_core_s o_core
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);

    // Write cycles are real transfers that drive the data lines
    a_write_drives_data: assert property (
        !o_bus.rnw |-> o_bus.memory_cycle_valid && o_bus.data_oe)
        else $error("write cycle without valid or data drive");
    a_read_no_drive: assert property (
        o_bus.rnw |-> !o_bus.data_oe)
        else $error("data driven on a read or idle cycle");
    // Opcode fetch is the first cycle seen after reset
    a_fetch_from_reset: assert property (
        $past(i_rst) |-> o_bus.memory_cycle_valid && o_bus.rnw
        && o_bus.addr == cbs_pkg::RESET_PC)
        else $error("first cycle after reset is not a fetch");
    // A store always starts with an idle cycle at the same address
    a_idle_before_write: assert property (
        $fell(o_bus.rnw) |-> !$past(o_bus.memory_cycle_valid)
        && o_bus.addr == $past(o_bus.addr))
        else $error("write not preceded by idle at its address");
    a_write_pair_next: assert property (
        !o_bus.rnw && !$past(o_bus.rnw)
        |-> o_bus.addr == $past(o_bus.addr) + 16'h0001)
        else $error("second write byte not at next address");
    a_writes_end_soon: assert property (
        $fell(o_bus.rnw) |-> ##[1:2] o_bus.rnw)
        else $error("write burst longer than two cycles");
    // Second idle of an indexed access adds the offset without carry
    a_idle_no_carry: assert property (
        !o_bus.memory_cycle_valid && !$past(o_bus.memory_cycle_valid)
        |-> o_bus.addr[15:8] == $past(o_bus.addr[15:8])
        && o_bus.addr[7:0]
        == 8'($past(o_bus.addr[7:0]) + $past(i_data, 2)))
        else $error("partial index sum wrong");
    // After the two idles the carried sum is read or fetched
    a_carried_sum: assert property (
        $past(!o_bus.memory_cycle_valid) && $past(!o_bus.memory_cycle_valid, 2)
        |-> o_bus.memory_cycle_valid && o_bus.rnw && o_bus.addr
        == $past(o_bus.addr, 2) + 16'($past(i_data, 3)))
        else $error("carried index sum wrong");
endmodule

bind cbs_sequencer cbs_sequencer_properties u_props (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_data(i_data),
    .o_bus(o_bus),
    .o_core(o_core)
);

//--- bench/tb_top.sv
// Self-checking bench running a small program through the sequencer
`timescale 1ns/1ps
module tb_top;
    logic i_core_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [7:0] i_data;
    cbs_pkg::cbs_bus_s o_bus;
    cbs_pkg::cbs_core_s o_core;
    int num_errors = 0;
    int n_compared = 0;
    localparam logic [7:0] PROG [30] = '{8'h86, 8'h5a, 8'hce, 8'h12, 8'h34,
        8'h8c, 8'h00, 8'h01, 8'h96, 8'h40, 8'hde, 8'h42, 8'h9c, 8'h42,
        8'h97, 8'h50, 8'h8e, 8'h23, 8'h45, 8'h9f, 8'h60, 8'hdf, 8'h62,
        8'he6, 8'h20, 8'hae, 8'h10, 8'h03, 8'h6e, 8'h30};

    // 25 MHz core clock
    always #20 i_core_clk = ~i_core_clk;

    cbs_sequencer u_dut (.i_core_clk(i_core_clk), .i_rst(i_rst),
        .i_data(i_data), .o_bus(o_bus), .o_core(o_core));
    cbs_memory u_mem (.i_core_clk(i_core_clk), .i_bus(o_bus),
        .o_data(i_data));

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        n_compared++;
        if (seen !== want) begin
            num_errors++;
            $display("unexpected at %0t: got %h want %h", $time, seen, want);
        end
    endtask

    // One bus cycle, looked at mid-period when all fields are settled
    task automatic cyc(input logic [15:0] a, input logic v, input logic w,
                       input logic [7:0] d);
        @(negedge i_core_clk);
        check({o_bus.addr, o_bus.memory_cycle_valid, o_bus.rnw}, {a, v, w});
        if (!w) begin
            check({o_bus.data_oe, o_bus.data}, {1'b1, d});
        end else begin
            check(o_bus.data_oe, 1'b0);
        end
    endtask

    // Consecutive valid reads from a running address
    task automatic reads(input logic [15:0] a, input int n);
        for (int k = 0; k < n; k++) begin
            cyc(a + 16'(k), 1'b1, 1'b1, 8'h00);
        end
    endtask

    // The two internal cycles of every indexed access
    task automatic idles(input logic [15:0] x, input logic [7:0] off);
        cyc(x, 1'b0, 1'b1, 8'h00);
        cyc({x[15:8], x[7:0] + off}, 1'b0, 1'b1, 8'h00);
    endtask

    // Let the edge ending the instruction land before looking at registers
    task automatic settle();
        @(posedge i_core_clk);
        #1;
    endtask

    task automatic t_immediate();
        reads(16'h0000, 8);
        settle();
        check(o_core.acc_a, 8'h5a);
        check(o_core.idx, 16'h1234);
        $display("test immediate done, errors %0d", num_errors);
    endtask

    task automatic t_direct();
        reads(16'h0008, 2);
        cyc(16'h0040, 1'b1, 1'b1, 8'h00);
        reads(16'h000a, 2);
        reads(16'h0042, 2);
        reads(16'h000c, 2);
        reads(16'h0042, 2);
        settle();
        check(o_core.acc_a, 8'ha5);
        check(o_core.idx, 16'h12f0);
        $display("test direct done, errors %0d", num_errors);
    endtask

    task automatic t_store();
        reads(16'h000e, 2);
        cyc(16'h0050, 1'b0, 1'b1, 8'h00);
        cyc(16'h0050, 1'b1, 1'b0, 8'ha5);
        reads(16'h0010, 5);
        cyc(16'h0060, 1'b0, 1'b1, 8'h00);
        cyc(16'h0060, 1'b1, 1'b0, 8'h23);
        cyc(16'h0061, 1'b1, 1'b0, 8'h45);
        reads(16'h0015, 2);
        cyc(16'h0062, 1'b0, 1'b1, 8'h00);
        cyc(16'h0062, 1'b1, 1'b0, 8'h12);
        cyc(16'h0063, 1'b1, 1'b0, 8'hf0);
        settle();
        check({u_mem.mem[16'h0050], u_mem.mem[16'h0060]}, 16'ha523);
        check({u_mem.mem[16'h0062], u_mem.mem[16'h0063]}, 16'h12f0);
        check(o_core.sp, 16'h2345);
        $display("test store done, errors %0d", num_errors);
    endtask

    task automatic t_indexed();
        reads(16'h0017, 2);
        idles(16'h12f0, 8'h20);
        cyc(16'h1310, 1'b1, 1'b1, 8'h00);
        reads(16'h0019, 2);
        idles(16'h12f0, 8'h10);
        reads(16'h1300, 2);
        settle();
        check(o_core.acc_b, 8'h3c);
        check(o_core.sp, 16'h7788);
        $display("test indexed done, errors %0d", num_errors);
    endtask

    task automatic t_jump();
        reads(16'h001b, 3);
        idles(16'h12f0, 8'h30);
        reads(16'h1320, 3);
        $display("test jump done, errors %0d", num_errors);
    endtask

    // Reset in mid-run restarts the fetch from the reset address
    task automatic t_reset();
        @(posedge i_core_clk);
        i_rst <= 1'b1;
        settle();
        check({o_bus.addr, o_bus.memory_cycle_valid, o_bus.rnw, o_bus.data_oe},
              {cbs_pkg::RESET_PC, 3'h6});
        check({o_core.pc, o_core.acc_a, o_core.acc_b}, 32'h0);
        check({o_core.idx, o_core.sp}, 32'h0);
        @(posedge i_core_clk);
        i_rst <= 1'b0;
        reads(16'h0000, 2);
        settle();
        check(o_core.acc_a, 8'h5a);
        $display("test reset done, errors %0d", num_errors);
    endtask

    task automatic complete_run();
        $display("compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Watchdog against a hung sequence
    initial begin
        repeat (2000) @(posedge i_core_clk);
        num_errors++;
        complete_run();
    end

    // Program and data, then reset and the scenarios in program order
    initial begin
        #1;
        for (int k = 0; k < 30; k++) begin
            u_mem.mem[k] = PROG[k];
        end
        u_mem.mem[16'h0040] = 8'ha5;
        u_mem.mem[16'h0042] = 8'h12;
        u_mem.mem[16'h0043] = 8'hf0;
        u_mem.mem[16'h1310] = 8'h3c;
        u_mem.mem[16'h1300] = 8'h77;
        u_mem.mem[16'h1301] = 8'h88;
        u_mem.mem[16'h1320] = 8'h81;
        u_mem.mem[16'h1321] = 8'h01;
        repeat (16) @(posedge i_core_clk);
        i_rst <= 1'b0;
        t_immediate();
        t_direct();
        t_store();
        t_indexed();
        t_jump();
        t_reset();
        complete_run();
    end
endmodule
